/* src/sic_defs.svh */
// Summary of operation
// - The external bus is 32 data bits and 19 longword address bits, clocked at half CLK.
// - Static memory, boot storage and slow peripherals sit in separate spaces, each with its own timing.
// - Requests are taken from both the processor core and the microengines.
// - The static memory space spans 8 Mbytes of flow-through or pipelined parts.
// - Core byte addresses and microengine longword addresses both become longword bus addresses.
// - The word address pins carry exactly the low 19 bits of the internal longword address.
// - Four active-low device selects are decoded from the internal address.
// - Two active-low bank selects, upper and lower, are decoded as well, for up to eight banks.
// - Device and bank selects follow one of four memory configurations chosen by configuration.
// - With the switch wait enabled, one wait state is added when a select boundary is crossed.
// - A configuration bit picks flow-through parts (latency 2) or pipelined parts (latency 3).
// - No other memory type, single-cycle-deselect included, is supported.
// - Flow-through read data passes an extra register so it arrives on the same cycle as pipelined.
// - That extra register is loaded from the returned copy of the forwarded memory clock.
// - With flow-through parts a write after a read starts one bus cycle earlier.
`ifndef SIC_DEFS_SVH
`define SIC_DEFS_SVH

// ************************************************************
// Address spaces (bits 22:21 of the longword address)
// ************************************************************
`define SIC_SPACE_SSRAM 2'h0
`define SIC_SPACE_BOOT 2'h1
`define SIC_SPACE_SLOW 2'h2
`define SIC_LW_AW 23
`define SIC_OFS_AW 21
`define SIC_PIN_AW 19
`define SIC_DW 32

// ************************************************************
// Memory configurations
// ************************************************************
`define SIC_CFG_FOUR_DEV 2'h0
`define SIC_CFG_TWO_DEV_BANKS 2'h1
`define SIC_CFG_FOUR_DEV_BANKS 2'h2
`define SIC_CFG_ONE_DEV 2'h3

// ************************************************************
// Read latency in bus cycles
// ************************************************************
`define SIC_LAT_FLOW 2'h2
`define SIC_LAT_PIPE 2'h3

`endif

/* src/sic_pkg.sv */
package sic_pkg;
    typedef enum logic [1:0] {
        SIC_IDLE = 2'h0,
        SIC_CHECK = 2'h1,
        SIC_SLOW = 2'h3
    } sic_state_t;
    typedef logic [3:0] sic_ce_t;
endpackage

/* src/sic_sel_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sic_sel_if;
    logic [20:0] addr;
    logic [1:0] cfg;
    sic_pkg::sic_ce_t ce_n;
    logic high_n;
    logic low_n;
    modport dec (input addr, input cfg, output ce_n, output high_n, output low_n);
    modport user (output addr, output cfg, input ce_n, input high_n, input low_n);
endinterface
`default_nettype wire

/* src/sic_sel_dec.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sic_defs.svh"
module sic_sel_dec (
    sic_sel_if.dec sel
);
    // ************************************************************
    // Select decode from bits above the pin address, plus A18 for the banks of the four-device banked mode
    // ************************************************************
    always_comb begin
        sel.ce_n = 4'hF;
        sel.high_n = 1'b1;
        sel.low_n = 1'b1;
        case (sel.cfg)
            `SIC_CFG_FOUR_DEV: begin
                sel.ce_n[sel.addr[20:19]] = 1'b0;
            end
            `SIC_CFG_TWO_DEV_BANKS: begin
                sel.ce_n[{1'b0, sel.addr[20]}] = 1'b0;
                sel.high_n = ~sel.addr[19];
                sel.low_n = sel.addr[19];
            end
            `SIC_CFG_FOUR_DEV_BANKS: begin
                // Bank bit shares A18, so each bank holds 256K words
                sel.ce_n[sel.addr[20:19]] = 1'b0;
                sel.high_n = ~sel.addr[18];
                sel.low_n = sel.addr[18];
            end
            default: begin
                sel.ce_n[0] = 1'b0;
            end
        endcase
    end
endmodule // sic_sel_dec
`default_nettype wire

/* src/sic_arb.sv */
`timescale 1ns/100ps
`default_nettype none
module sic_arb (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] req,
    input wire logic take,
    output logic valid,
    output logic gnt
);
    logic last_reg;

    // ************************************************************
    // Round robin between core (0) and microengines (1)
    // ************************************************************
    assign valid = |req;
    always_comb begin
        if (req == 2'h3) begin
            gnt = ~last_reg;
        end else begin
            gnt = req[1];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            last_reg <= 1'b1;
        end else if (take && valid) begin
            last_reg <= gnt;
        end
    end
endmodule // sic_arb
`default_nettype wire

/* src/sic_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sic_defs.svh"
module sic_ctrl (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CORE_REQ,
    input wire logic CORE_WR,
    input wire logic [24:0] CORE_ADDR,
    input wire logic [31:0] CORE_WDATA,
    output logic CORE_ACK,
    output logic [31:0] CORE_RDATA,
    input wire logic ME_REQ,
    input wire logic ME_WR,
    input wire logic [22:0] ME_ADDR,
    input wire logic [31:0] ME_WDATA,
    output logic ME_ACK,
    output logic [31:0] ME_RDATA,
    input wire logic [1:0] MEM_CONFIG,
    input wire logic FLOW_THRU,
    input wire logic SWITCH_WAIT_EN,
    input wire logic [3:0] BOOT_CYCLES,
    input wire logic [3:0] SLOW_CYCLES,
    output logic BUSY,
    output logic SCLK,
    input wire logic RETURNED_CLOCK_IN,
    output logic [18:0] SA,
    output logic [3:0] CE_N,
    output logic HIGH_EN_N,
    output logic LOW_EN_N,
    output logic SLOW_EN_N,
    output logic SP_CE_N,
    output logic WE_N,
    output logic OE_N,
    input wire logic [31:0] DQ_IN,
    output logic [31:0] DQ_OUT,
    output logic DQ_OE
);
    sic_pkg::sic_state_t state_reg;
    logic sclk_reg;
    logic bus_tick;
    logic arb_valid;
    logic arb_gnt;
    logic take;
    logic [1:0] pend_reg;
    logic cur_src_reg;
    logic cur_wr_reg;
    logic [22:0] cur_addr_reg;
    logic [31:0] cur_wdata_reg;
    logic [1:0] cur_space;
    logic [5:0] cur_sel;
    logic [5:0] last_sel_reg;
    logic last_valid_reg;
    logic waited_reg;
    logic [1:0] turn_reg;
    logic [2:0] pipe_v_reg;
    logic [2:0] pipe_src_reg;
    logic [3:0] slow_cnt_reg;
    logic [31:0] dq_s1_reg;
    logic [31:0] dq_s2_reg;
    logic rclk_s1_reg;
    logic rclk_s2_reg;
    logic rclk_s3_reg;
    logic [31:0] ft_reg;
    logic [31:0] rd_data;
    logic issue_ss;
    logic issue_slow;
    logic issue_none;
    logic need_wait;
    logic ss_done;
    logic slow_done;
    logic ack_any;
    logic ack_src;
    logic [31:0] ack_data;
    logic [22:0] core_lw;
    sic_sel_if sel ();

    // ************************************************************
    // Bus clock at half CLK, forwarded out
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sclk_reg <= 1'b0;
        end else begin
            sclk_reg <= ~sclk_reg;
        end
    end
    // Pins change only on these cycles, one per bus period, or on the cycle a slow cycle ends
    assign bus_tick = sclk_reg;
    assign SCLK = sclk_reg;

    // ************************************************************
    // Requester arbitration
    // ************************************************************
    assign core_lw = CORE_ADDR[24:2];
    assign take = (state_reg == sic_pkg::SIC_IDLE) && bus_tick;

    sic_arb u_arb (
        .clk(CLK),
        .reset(RESET),
        .req({ME_REQ & ~pend_reg[1], CORE_REQ & ~pend_reg[0]}),
        .take(take),
        .valid(arb_valid),
        .gnt(arb_gnt)
    );

    always_ff @(posedge CLK) begin
        if (RESET) begin
            cur_src_reg <= 1'b0;
            cur_wr_reg <= 1'b0;
            cur_addr_reg <= 23'h000000;
            cur_wdata_reg <= 32'h00000000;
        end else if (take && arb_valid) begin
            cur_src_reg <= arb_gnt;
            cur_wr_reg <= arb_gnt ? ME_WR : CORE_WR;
            cur_addr_reg <= arb_gnt ? ME_ADDR : core_lw;
            cur_wdata_reg <= arb_gnt ? ME_WDATA : CORE_WDATA;
        end
    end

    // A requester holds its request until acked, so block re-taking it
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pend_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (take && arb_valid && (arb_gnt == i[0])) begin
                    pend_reg[i] <= 1'b1;
                end else if ((ack_any && (ack_src == i[0]))
                    || (ss_done && (pipe_src_reg[2] == i[0]))) begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Space and select decode
    // ************************************************************
    assign cur_space = cur_addr_reg[22:21];
    assign sel.addr = cur_addr_reg[20:0];
    assign sel.cfg = MEM_CONFIG;

    sic_sel_dec u_dec (
        .sel(sel)
    );

    assign cur_sel = {sel.ce_n, sel.high_n, sel.low_n};
    assign need_wait = SWITCH_WAIT_EN && last_valid_reg && !waited_reg
        && (cur_sel != last_sel_reg);

    always_comb begin
        issue_ss = 1'b0;
        issue_slow = 1'b0;
        issue_none = 1'b0;
        if (state_reg == sic_pkg::SIC_CHECK && bus_tick) begin
            case (cur_space)
                `SIC_SPACE_SSRAM: begin
                    // Write waits out the read turnaround window
                    issue_ss = !(cur_wr_reg && turn_reg != 2'h0) && !need_wait;
                end
                `SIC_SPACE_BOOT, `SIC_SPACE_SLOW: begin
                    // Slow cycles own the bus; let reads in flight drain
                    issue_slow = (pipe_v_reg == 3'h0);
                end
                default: begin
                    issue_none = 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_reg <= sic_pkg::SIC_IDLE;
        end else begin
            case (state_reg)
                sic_pkg::SIC_IDLE: begin
                    if (take && arb_valid) begin
                        state_reg <= sic_pkg::SIC_CHECK;
                    end
                end
                sic_pkg::SIC_CHECK: begin
                    if (issue_slow) begin
                        state_reg <= sic_pkg::SIC_SLOW;
                    end else if (issue_ss || issue_none) begin
                        state_reg <= sic_pkg::SIC_IDLE;
                    end
                end
                sic_pkg::SIC_SLOW: begin
                    if (slow_done) begin
                        state_reg <= sic_pkg::SIC_IDLE;
                    end
                end
                default: begin
                    state_reg <= sic_pkg::SIC_IDLE;
                end
            endcase
        end
    end

    // Wait state and select history
    always_ff @(posedge CLK) begin
        if (RESET) begin
            waited_reg <= 1'b0;
            last_valid_reg <= 1'b0;
            last_sel_reg <= 6'h3F;
        end else if (state_reg == sic_pkg::SIC_CHECK && bus_tick) begin
            if (issue_ss) begin
                waited_reg <= 1'b0;
                last_valid_reg <= 1'b1;
                last_sel_reg <= cur_sel;
            end else if (need_wait && cur_space == `SIC_SPACE_SSRAM) begin
                waited_reg <= 1'b1;
            end else if (issue_slow) begin
                // Slow cycles park the selects, so the next access owes no switch wait
                last_valid_reg <= 1'b0;
            end
        end
    end

    // Turnaround after a read, shorter for flow-through parts
    always_ff @(posedge CLK) begin
        if (RESET) begin
            turn_reg <= 2'h0;
        end else if (bus_tick) begin
            if (issue_ss && !cur_wr_reg) begin
                turn_reg <= FLOW_THRU ? (`SIC_LAT_FLOW - 2'h1) : (`SIC_LAT_PIPE - 2'h1);
            end else if (turn_reg != 2'h0) begin
                turn_reg <= turn_reg - 2'h1;
            end
        end
    end

    // Slow space cycle counter, in CLK cycles
    always_ff @(posedge CLK) begin
        if (RESET) begin
            slow_cnt_reg <= 4'h0;
        end else if (issue_slow) begin
            slow_cnt_reg <= (cur_space == `SIC_SPACE_BOOT) ? BOOT_CYCLES : SLOW_CYCLES;
        end else if (slow_cnt_reg != 4'h0) begin
            slow_cnt_reg <= slow_cnt_reg - 4'h1;
        end
    end
    assign slow_done = (state_reg == sic_pkg::SIC_SLOW) && (slow_cnt_reg == 4'h0);

    // ************************************************************
    // Read pipeline and data capture
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pipe_v_reg <= 3'h0;
            pipe_src_reg <= 3'h0;
        end else if (bus_tick) begin
            pipe_v_reg <= {pipe_v_reg[1:0], issue_ss & ~cur_wr_reg};
            pipe_src_reg <= {pipe_src_reg[1:0], cur_src_reg};
        end
    end
    // Same delivery slot in both modes
    assign ss_done = bus_tick && pipe_v_reg[`SIC_LAT_PIPE - 2'h1];

    // Pin inputs pass two flops before use
    always_ff @(posedge CLK) begin
        if (RESET) begin
            dq_s1_reg <= 32'h00000000;
            dq_s2_reg <= 32'h00000000;
            rclk_s1_reg <= 1'b0;
            rclk_s2_reg <= 1'b0;
            rclk_s3_reg <= 1'b0;
        end else begin
            dq_s1_reg <= DQ_IN;
            dq_s2_reg <= dq_s1_reg;
            rclk_s1_reg <= RETURNED_CLOCK_IN;
            rclk_s2_reg <= rclk_s1_reg;
            rclk_s3_reg <= rclk_s2_reg;
        end
    end

    // Extra stage for flow-through parts, timed by the returned clock
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ft_reg <= 32'h00000000;
        end else if (rclk_s2_reg && !rclk_s3_reg) begin
            ft_reg <= dq_s2_reg;
        end
    end
    assign rd_data = FLOW_THRU ? ft_reg : dq_s2_reg;

    // ************************************************************
    // Acknowledge and read data return
    // ************************************************************
    // Ack for the access in hand; static memory read returns are acked apart
    always_comb begin
        ack_any = (issue_ss && cur_wr_reg) || issue_none || slow_done;
        ack_src = cur_src_reg;
        ack_data = 32'h00000000;
        if (slow_done && !cur_wr_reg) begin
            ack_data = dq_s2_reg;
        end
    end

    // A read return may share a tick with the other source's write issue
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CORE_ACK <= 1'b0;
            ME_ACK <= 1'b0;
            CORE_RDATA <= 32'h00000000;
            ME_RDATA <= 32'h00000000;
        end else begin
            CORE_ACK <= (ss_done && !pipe_src_reg[2]) || (ack_any && !ack_src);
            ME_ACK <= (ss_done && pipe_src_reg[2]) || (ack_any && ack_src);
            if (ss_done && !pipe_src_reg[2]) begin
                CORE_RDATA <= rd_data;
            end else if (ack_any && !ack_src) begin
                CORE_RDATA <= ack_data;
            end
            if (ss_done && pipe_src_reg[2]) begin
                ME_RDATA <= rd_data;
            end else if (ack_any && ack_src) begin
                ME_RDATA <= ack_data;
            end
        end
    end

    assign BUSY = (state_reg != sic_pkg::SIC_IDLE) || (pipe_v_reg != 3'h0);

    // ************************************************************
    // External pins
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (RESET) begin
            SA <= 19'h00000;
            CE_N <= 4'hF;
            HIGH_EN_N <= 1'b1;
            LOW_EN_N <= 1'b1;
            SLOW_EN_N <= 1'b1;
            SP_CE_N <= 1'b1;
            WE_N <= 1'b1;
            OE_N <= 1'b1;
            DQ_OUT <= 32'h00000000;
            DQ_OE <= 1'b0;
        end else if (issue_ss || issue_slow) begin
            SA <= cur_addr_reg[`SIC_PIN_AW - 1:0];
            CE_N <= (cur_space == `SIC_SPACE_SLOW) ? 4'hF : sel.ce_n;
            HIGH_EN_N <= issue_ss ? sel.high_n : 1'b1;
            LOW_EN_N <= issue_ss ? sel.low_n : 1'b1;
            SLOW_EN_N <= ~issue_slow;
            SP_CE_N <= ~(issue_slow && cur_space == `SIC_SPACE_SLOW);
            WE_N <= ~cur_wr_reg;
            OE_N <= cur_wr_reg;
            DQ_OUT <= cur_wdata_reg;
            DQ_OE <= cur_wr_reg;
        end else if (slow_done || (bus_tick && state_reg != sic_pkg::SIC_SLOW)) begin
            CE_N <= 4'hF;
            HIGH_EN_N <= 1'b1;
            LOW_EN_N <= 1'b1;
            SLOW_EN_N <= 1'b1;
            SP_CE_N <= 1'b1;
            WE_N <= 1'b1;
            // Output enable stays on while reads are in flight
            OE_N <= (pipe_v_reg[1:0] == 2'h0);
            DQ_OE <= 1'b0;
        end
    end
endmodule // sic_ctrl
`default_nettype wire

/* bench/sic_ssram_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Static memory parts on the shared bus
// ************************************************************
module sic_ssram_model (
    input wire logic SCLK,
    input wire logic FLOW_THRU,
    input wire logic [18:0] SA,
    input wire logic [3:0] CE_N,
    input wire logic HIGH_EN_N,
    input wire logic LOW_EN_N,
    input wire logic SLOW_EN_N,
    input wire logic WE_N,
    input wire logic DQ_OE,
    input wire logic [31:0] DQ_OUT,
    output logic [31:0] DQ_IN
);
    logic [31:0] mem [bit [24:0]];
    logic [31:0] q1, q2, last;
    logic v1, v2, sel;
    bit [24:0] key;
    assign key = {SA, CE_N, HIGH_EN_N, LOW_EN_N};
    assign sel = (CE_N != 4'hF) && SLOW_EN_N;
    always @(posedge SCLK) begin
        if (sel && !WE_N) begin
            mem[key] = DQ_OUT;
        end
        // Flow parts drive one period after the address, pipelined ones two
        v1 <= sel && WE_N;
        q1 <= mem.exists(key) ? mem[key] : 32'h0;
        v2 <= v1;
        q2 <= q1;
        last <= DQ_IN;
    end
    // Released bus shows the inverse of the last value, never a stale copy
    assign #4 DQ_IN = DQ_OE ? DQ_OUT : (FLOW_THRU ? (v1 ? q1 : ~last) : (v2 ? q2 : ~last));
endmodule // sic_ssram_model
`default_nettype wire

/* bench/sic_ctrl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Port checker
// ************************************************************
module sic_ctrl_monitor (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CORE_REQ,
    input wire logic CORE_ACK,
    input wire logic ME_ACK,
    input wire logic SCLK,
    input wire logic [3:0] CE_N,
    input wire logic SLOW_EN_N,
    input wire logic SP_CE_N,
    input wire logic WE_N,
    input wire logic OE_N,
    input wire logic DQ_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence ssram_write_start;
        $fell(WE_N) && SLOW_EN_N;
    endsequence
    sequence one_bus_period;
        !WE_N ##1 WE_N;
    endsequence
    a_sclk_toggle: assert property (!$past(RESET) |-> SCLK != $past(SCLK))
        else $error("bus clock not at half rate");
    a_core_ack_pulse: assert property (CORE_ACK |=> !CORE_ACK)
        else $error("core ack longer than one cycle");
    a_me_ack_pulse: assert property (ME_ACK |=> !ME_ACK)
        else $error("engine ack longer than one cycle");
    a_select_onehot: assert property ($onehot0(~CE_N))
        else $error("more than one device select low");
    a_write_selected: assert property (!WE_N |-> (CE_N != 4'hF || !SP_CE_N))
        else $error("write strobe without a select");
    a_read_no_drive: assert property (!OE_N |-> !DQ_OE)
        else $error("data bus driven during read");
    a_write_launch: assert property (ssram_write_start |-> $past(SCLK))
        else $error("write launched off the bus clock fall");
    a_strobe_length: assert property (ssram_write_start |-> ##1 one_bus_period)
        else $error("write strobe not one bus period");
    a_ack_bounded: assert property ($rose(CORE_REQ) |-> ##[1:80] CORE_ACK)
        else $error("core request not acknowledged");
    a_reset_quiet: assert property ($fell(RESET) |-> CE_N == 4'hF && WE_N && !DQ_OE
        && !CORE_ACK && !ME_ACK)
        else $error("outputs active after reset");
endmodule // sic_ctrl_monitor
bind sic_ctrl sic_ctrl_monitor chk_i (.CLK(CLK), .RESET(RESET), .CORE_REQ(CORE_REQ),
    .CORE_ACK(CORE_ACK), .ME_ACK(ME_ACK), .SCLK(SCLK), .CE_N(CE_N), .SLOW_EN_N(SLOW_EN_N),
    .SP_CE_N(SP_CE_N), .WE_N(WE_N), .OE_N(OE_N), .DQ_OE(DQ_OE));
`default_nettype wire

/* bench/ssram_interface_controller_test.sv */
`timescale 1ns/100ps
`default_nettype none
module ssram_interface_controller_test;
    logic clk, reset, core_req, core_wr, core_ack, me_req, me_wr, me_ack, flow_thru, busy;
    logic switch_wait_en, sclk, returned_clock_in, high_en_n, low_en_n, slow_en_n, sp_ce_n;
    logic we_n, oe_n, dq_oe, we_prev, oe_prev, busy_seen;
    logic [24:0] core_addr;
    logic [22:0] me_addr;
    logic [31:0] core_wdata, core_rdata, me_wdata, me_rdata, dq_in, dq_out, q, q_wr;
    logic [1:0] mem_config, cap_bank;
    logic [3:0] boot_cycles, slow_cycles, ce_n, cap_ce;
    logic [18:0] sa, cap_sa;
    logic [20:0] ofs;
    logic cap_sp;
    int n_errors, checked, cyc, we_len, we_t, we_t0, rd_t, g0, g1, g2;
    // Loop-back trace delay of the forwarded clock
    assign #3 returned_clock_in = sclk;
    sic_ctrl uut (.CLK(clk), .RESET(reset), .CORE_REQ(core_req), .CORE_WR(core_wr),
        .CORE_ADDR(core_addr), .CORE_WDATA(core_wdata), .CORE_ACK(core_ack),
        .CORE_RDATA(core_rdata), .ME_REQ(me_req), .ME_WR(me_wr), .ME_ADDR(me_addr),
        .ME_WDATA(me_wdata), .ME_ACK(me_ack), .ME_RDATA(me_rdata), .MEM_CONFIG(mem_config),
        .FLOW_THRU(flow_thru), .SWITCH_WAIT_EN(switch_wait_en), .BOOT_CYCLES(boot_cycles),
        .SLOW_CYCLES(slow_cycles), .BUSY(busy), .SCLK(sclk),
        .RETURNED_CLOCK_IN(returned_clock_in), .SA(sa), .CE_N(ce_n), .HIGH_EN_N(high_en_n),
        .LOW_EN_N(low_en_n), .SLOW_EN_N(slow_en_n), .SP_CE_N(sp_ce_n), .WE_N(we_n),
        .OE_N(oe_n), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
    sic_ssram_model mem_i (.SCLK(sclk), .FLOW_THRU(flow_thru), .SA(sa), .CE_N(ce_n),
        .HIGH_EN_N(high_en_n), .LOW_EN_N(low_en_n), .SLOW_EN_N(slow_en_n), .WE_N(we_n),
        .DQ_OE(dq_oe), .DQ_OUT(dq_out), .DQ_IN(dq_in));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ************************************************************
    // Pin capture: strobe starts and widths in CLK cycles
    // ************************************************************
    always @(posedge clk) begin
        cyc++;
        busy_seen = busy_seen | busy;
        if (!we_n) begin
            we_len++;
            cap_sa = sa;
            cap_ce = ce_n;
            cap_bank = {high_en_n, low_en_n};
            cap_sp = sp_ce_n;
        end
        if (!we_n && we_prev) begin
            we_t0 = we_t;
            we_t = cyc;
        end
        if (!oe_n && oe_prev) begin
            rd_t = cyc;
        end
        we_prev = we_n;
        oe_prev = oe_n;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One access on either requester port; lw is always a longword address
    task automatic op(input bit me, input logic wr, input logic [22:0] lw,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(negedge clk);
        if (me) begin
            {me_wr, me_addr, me_wdata, me_req} = {wr, lw, d, 1'b1};
        end else begin
            {core_wr, core_addr, core_wdata, core_req} = {wr, lw, 2'h0, d, 1'b1};
        end
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((me ? me_ack : core_ack) !== 1'b1 && n < 200);
        r = me ? me_rdata : core_rdata;
        if (n >= 200) begin
            chk("ack", 1, 0);
        end
        @(negedge clk);
        if (me) begin
            me_req = 1'b0;
        end else begin
            core_req = 1'b0;
        end
        // Let pin captures of this access complete
        @(negedge clk);
    endtask
    // Expected {CE_N, HIGH_EN_N, LOW_EN_N} for a configuration and offset
    function automatic logic [5:0] exp_sel(input logic [1:0] c, input logic [20:0] a);
        case (c)
            2'h0: exp_sel = {~(4'h1 << a[20:19]), 2'h3};
            2'h1: exp_sel = {~(4'h1 << a[20]), ~a[19], a[19]};
            2'h2: exp_sel = {~(4'h1 << a[20:19]), ~a[18], a[18]};
            default: exp_sel = {4'hE, 2'h3};
        endcase
    endfunction
    initial begin
        {reset, core_req, core_wr, me_req, me_wr, flow_thru, switch_wait_en} = 7'h41;
        {core_addr, me_addr, core_wdata, me_wdata, mem_config} = '0;
        {boot_cycles, slow_cycles} = {4'h3, 4'h5};
        {we_prev, oe_prev, n_errors, checked, cyc, we_len, we_t, we_t0, rd_t} = '1;
        {n_errors, checked, cyc} = '0;
        repeat (4) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        chk("ce_n", 32'hF, ce_n);
        chk("dq_oe", 0, dq_oe);
        // Every configuration in both memory modes: write by core, read back by engine
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 4; c++) begin
                flow_thru = f[0];
                mem_config = c[1:0];
                ofs = {c[1:0], f[0], 18'h2A5A5};
                op(0, 1, {2'h0, ofs}, 32'hC0DE0000 | c | (f << 4), q);
                chk("sa", ofs[18:0], cap_sa);
                chk("selects", exp_sel(c[1:0], ofs), {cap_ce, cap_bank});
                op(1, 0, {2'h0, ofs}, 0, q);
                chk("read data", 32'hC0DE0000 | c | (f << 4), q);
            end
        end
        // Device switch wait, disabled then enabled
        {flow_thru, mem_config} = 3'h0;
        for (int e = 0; e < 2; e++) begin
            switch_wait_en = e[0];
            op(0, 1, 23'h000010, 32'h11, q);
            op(0, 1, 23'h080010, 32'h22, q);
            g1 = e ? we_t - we_t0 : g1;
            g0 = e ? g0 : we_t - we_t0;
        end
        op(0, 1, 23'h080011, 32'h33, q);
        chk("switch wait", g0 + 2, g1);
        chk("no switch", g0, we_t - we_t0);
        // Write queued behind a read: turnaround per memory mode
        for (int f = 0; f < 2; f++) begin
            flow_thru = f[0];
            fork
                op(1, 0, 23'h000010, 0, q);
                begin
                    @(negedge clk);
                    op(0, 1, 23'h000020, 32'h44, q_wr);
                end
            join
            chk("read under write", 32'h11, q);
            g2 = f ? g2 - (we_t - rd_t) : we_t - rd_t;
        end
        chk("turnaround", 2, g2);
        // Slow and boot spaces keep their own strobe lengths
        we_len = 0;
        op(0, 1, 23'h400007, 32'h55, q);
        chk("slow strobe", 6, we_len);
        chk("slow select", 0, cap_sp);
        chk("slow ce", 32'hF, cap_ce);
        we_len = 0;
        op(1, 1, 23'h200007, 32'h66, q);
        chk("boot strobe", 4, we_len);
        busy_seen = 1'b0;
        op(0, 0, 23'h600003, 0, q);
        chk("unmapped", 0, q);
        chk("busy", 1, busy_seen);
        chk("idle", 0, busy);
        results();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule // ssram_interface_controller_test
`default_nettype wire
